// ---- verilog/adsq_consts.svh ----
// Register map, field positions and timing counts of the converter control
`ifndef ADSQ_CONSTS_SVH
`define ADSQ_CONSTS_SVH

// Word indices, byte address = index * 4
`define ADSQ_IDX_CTL 3'h0
`define ADSQ_IDX_RES1 3'h1
`define ADSQ_IDX_RES2 3'h2
`define ADSQ_IDX_RES3 3'h3
`define ADSQ_IDX_RES4 3'h4
`define ADSQ_IDX_OPT 3'h5

// Control/status fields
`define ADSQ_CCF_BIT 7
`define ADSQ_ZERO_BIT 6
`define ADSQ_SCAN_BIT 5
`define ADSQ_MULTI_CHANNEL_SELECT_BIT 4
`define ADSQ_SEL_HI 3
`define ADSQ_SEL_LO 0

// Option fields
`define ADSQ_OPT_CLOCK_SOURCE_SELECT 0
`define ADSQ_OPT_PU 1
`define ADSQ_OPT_RST 2'h0

// Conversion timing in conversion-clock steps, sync delay in bus clock cycles
`define ADSQ_SAMPLE_CYC 5'h0C
`define ADSQ_BIT_FIRST 5'h0C
`define ADSQ_BIT_END 5'h1C
`define ADSQ_CONV_LAST 5'h1F
`define ADSQ_SYNC_LAST 2'h1

// Channel codes
`define ADSQ_CH_REF_HI 4'hC
`define ADSQ_CH_REF_LO 4'hD
`define ADSQ_CH_HALF 4'hE
`define ADSQ_LAST_SLOT 2'h3

`endif

// ---- verilog/adsq_pkg.sv ----
// Types shared by the converter control modules
package adsq_pkg;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_CONV = 2'b01,
        SQ_SYNC = 2'b10,
        SQ_XFER = 2'b11
    } adsq_state_e;

    typedef logic [7:0] adsq_byte_t;

endpackage

// ---- verilog/adsq_sar.sv ----
// Successive-approximation step engine for one 8-bit conversion
`timescale 1ns/100ps
`include "adsq_consts.svh"

module adsq_sar (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_i,
    input wire logic step_i,
    input wire logic comp_i,
    // Results
    output logic sample_o,
    output logic [7:0] trial_o,
    output logic done_o,
    output logic [7:0] result_o
);

    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic busy_q;
    logic busy_d;
    logic [7:0] code_q;
    logic [7:0] code_d;
    logic [4:0] bit_n;
    logic [2:0] idx;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        code_d = code_q;
        bit_n = cnt_q - `ADSQ_BIT_FIRST;
        idx = 3'h7 - bit_n[3:1];
        // Restart wins, so a new start aborts a conversion
        if (start_i) begin
            cnt_d = 5'h00;
            busy_d = 1'b1;
            code_d = 8'h00;
        end else if (busy_q && step_i) begin
            // Two steps a bit; the trial leaves early so its judge sees it
            if (cnt_q >= `ADSQ_BIT_FIRST && cnt_q < `ADSQ_BIT_END) begin
                if (!cnt_q[0]) begin
                    code_d[idx] = 1'b1;
                end else if (!comp_i) begin
                    code_d[idx] = 1'b0;
                end
            end
            if (cnt_q == `ADSQ_CONV_LAST) begin // RULE_23
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            code_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            code_q <= code_d;
        end
    end

    assign sample_o = busy_q && (cnt_q < `ADSQ_SAMPLE_CYC); // RULE_20
    assign trial_o = code_d;
    assign done_o = busy_q && step_i && !start_i &&
                    (cnt_q == `ADSQ_CONV_LAST);
    assign result_o = code_q;

endmodule

// ---- verilog/adsq_top.sv ----
// Converter sequencer with Wishbone register slave
// Operation
// RULE_01: One of eleven sources is routed per conversion, set by select.
// RULE_02: A sequence is four conversions filling four result registers.
// RULE_03: Scan clear runs once and stops; scan set repeats round-robin.
// RULE_04: RC clocking adds a sync delay before each result update.
// RULE_05: Software picks the RC clock when bus clock is below 750 kHz.
// RULE_06: Software waits for the complete flag before using results.
// RULE_07: On bus clock the first result is valid 34 cycles after write.
// RULE_08: Control bit 7 is read-only status, bit 6 reads zero.
// RULE_09: Reset clears the complete flag only, not mode or select.
// RULE_10: Complete flag sets once all four results of a sequence land.
// RULE_11: Control write clears flag, aborts, and starts a new sequence.
// RULE_12: In scan mode the flag stays set while results keep updating.
// RULE_13: Multi clear converts the one selected channel four times.
// RULE_14: Multi set converts the group picked by the two high bits.
// RULE_15: In multi mode low select code fixes the result register.
// RULE_16: Codes 0-7 pins, 12-14 references and half, others reserved.
// RULE_17: Half reference forced by capacitor control during sampling.
// RULE_18: Four read-only 8-bit result registers.
// RULE_19: Results update only when no read is in progress.
// RULE_20: Sample switch closed only for the twelve-cycle sample.
// RULE_21: Software keeps clock select low for conversions below 2 MHz.
// RULE_22: Charge pump off after reset; software powers it up first.
// RULE_23: Each conversion takes 32 cycles; slots run in ascending order.
`timescale 1ns/100ps
`include "adsq_consts.svh"

module adsq_top (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:2] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Analog front end
    input wire logic COMP_I,
    input wire logic RC_OSC_I,
    output logic [7:0] PIN_SEL_O,
    output logic REF_HI_O,
    output logic REF_LO_O,
    output logic HALF_REF_O,
    output logic SAMPLE_O,
    output logic [7:0] DAC_CODE_O,
    output logic PUMP_EN_O,
    output logic RC_OSC_EN_O
);

    // Reset release synchroniser
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Pin synchronisers, first stage read only by second
    logic comp_meta_q;
    logic comp_q;
    logic rc_meta_q;
    logic rc_q;
    logic rc_last_q;
    logic rc_tick;

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            comp_meta_q <= 1'b0;
            comp_q <= 1'b0;
            rc_meta_q <= 1'b0;
            rc_q <= 1'b0;
            rc_last_q <= 1'b0;
        end else begin
            comp_meta_q <= COMP_I;
            comp_q <= comp_meta_q;
            rc_meta_q <= RC_OSC_I;
            rc_q <= rc_meta_q;
            rc_last_q <= rc_q;
        end
    end

    assign rc_tick = rc_q && !rc_last_q;

    // Bus slave
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic bus_req;
    logic wr_fire;
    logic wr_ctl;
    logic wr_opt;
    logic rd_busy;

    // Control, option and result storage
    logic [5:0] ctl_q;
    logic [5:0] ctl_d;
    logic [1:0] opt_q;
    logic [1:0] opt_d;
    logic ccf_q;
    logic ccf_d;
    adsq_pkg::adsq_byte_t res_q [0:3];
    adsq_pkg::adsq_byte_t res_d [0:3];
    logic [7:0] ctl_rd;

    // Sequencer
    adsq_pkg::adsq_state_e sq_q;
    adsq_pkg::adsq_state_e sq_d;
    logic [1:0] slot_q;
    logic [1:0] slot_d;
    logic [1:0] sync_q;
    logic [1:0] sync_d;
    adsq_pkg::adsq_byte_t hold_q;
    adsq_pkg::adsq_byte_t hold_d;
    logic sar_start;
    logic sar_step;
    logic sar_sample;
    logic sar_done;
    logic [7:0] sar_trial;
    logic [7:0] sar_res;
    logic [3:0] cur_ch;
    logic clock_source_select;
    logic scan;
    logic multi_channel_select;

    assign bus_req = CYC_I && STB_I;
    // A write lands on the edge where the master sees ack
    assign wr_fire = bus_req && WE_I && ack_q && SEL_I[0];
    assign wr_ctl = wr_fire && (ADR_I == `ADSQ_IDX_CTL); // RULE_11
    assign wr_opt = wr_fire && (ADR_I == `ADSQ_IDX_OPT);
    assign rd_busy = bus_req && !WE_I;
    assign clock_source_select = opt_q[`ADSQ_OPT_CLOCK_SOURCE_SELECT];
    assign scan = ctl_q[`ADSQ_SCAN_BIT];
    assign multi_channel_select = ctl_q[`ADSQ_MULTI_CHANNEL_SELECT_BIT];

    // Bit 6 is not stored and always reads zero
    assign ctl_rd = {ccf_q, 1'b0, ctl_q}; // RULE_08

    always_comb begin
        ack_d = bus_req && !ack_q;
        dat_d = 32'h0000_0000;
        if (ack_d && !WE_I) begin
            unique case (ADR_I)
                `ADSQ_IDX_CTL: dat_d[7:0] = ctl_rd;
                `ADSQ_IDX_RES1: dat_d[7:0] = res_q[0]; // RULE_18
                `ADSQ_IDX_RES2: dat_d[7:0] = res_q[1];
                `ADSQ_IDX_RES3: dat_d[7:0] = res_q[2];
                `ADSQ_IDX_RES4: dat_d[7:0] = res_q[3];
                `ADSQ_IDX_OPT: dat_d[1:0] = opt_q;
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // Mode and select hold across reset
    always_comb begin
        ctl_d = ctl_q;
        opt_d = opt_q;
        if (wr_ctl) begin
            ctl_d = DAT_I[`ADSQ_SCAN_BIT:`ADSQ_SEL_LO];
        end
        if (wr_opt) begin
            opt_d = DAT_I[1:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        ctl_q <= ctl_d; // RULE_09
    end

    // Pump stays off until software powers it up
    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            opt_q <= `ADSQ_OPT_RST; // RULE_22
        end else begin
            opt_q <= opt_d;
        end
    end

    // Channel of the current slot
    always_comb begin
        if (multi_channel_select) begin
            cur_ch = {ctl_q[`ADSQ_SEL_HI:2], slot_q}; // RULE_14
        end else begin
            cur_ch = ctl_q[`ADSQ_SEL_HI:`ADSQ_SEL_LO]; // RULE_13
        end
    end

    // RC steps synchronised; on bus clock the comparator shares this clock
    assign sar_step = clock_source_select ? rc_tick : 1'b1;

    always_comb begin
        sq_d = sq_q;
        slot_d = slot_q;
        sync_d = sync_q;
        hold_d = hold_q;
        ccf_d = ccf_q;
        sar_start = 1'b0;
        for (int i = 0; i < 4; i++) begin
            res_d[i] = res_q[i];
        end
        if (wr_ctl) begin
            // Abort whatever runs and begin at slot one
            sq_d = adsq_pkg::SQ_CONV; // RULE_11
            slot_d = 2'h0;
            ccf_d = 1'b0;
            sar_start = 1'b1;
        end else begin
            unique case (sq_q)
                adsq_pkg::SQ_IDLE: begin
                    sq_d = adsq_pkg::SQ_IDLE;
                end
                adsq_pkg::SQ_CONV: begin
                    if (sar_done) begin
                        hold_d = sar_res;
                        sync_d = 2'h0;
                        if (clock_source_select) begin
                            sq_d = adsq_pkg::SQ_SYNC; // RULE_04
                        end else begin
                            sq_d = adsq_pkg::SQ_XFER;
                        end
                    end
                end
                adsq_pkg::SQ_SYNC: begin
                    if (sync_q == `ADSQ_SYNC_LAST) begin
                        sq_d = adsq_pkg::SQ_XFER; // RULE_04
                    end else begin
                        sync_d = sync_q + 2'h1;
                    end
                end
                adsq_pkg::SQ_XFER: begin
                    // Deferred while a read is pending on the bus
                    if (!rd_busy) begin // RULE_19
                        res_d[slot_q] = hold_q; // RULE_15
                        if (slot_q == `ADSQ_LAST_SLOT) begin
                            ccf_d = 1'b1; // RULE_10
                            slot_d = 2'h0;
                            if (scan) begin
                                sq_d = adsq_pkg::SQ_CONV; // RULE_03
                                sar_start = 1'b1; // RULE_12
                            end else begin
                                sq_d = adsq_pkg::SQ_IDLE; // RULE_03
                            end
                        end else begin
                            slot_d = slot_q + 2'h1; // RULE_02
                            sq_d = adsq_pkg::SQ_CONV;
                            sar_start = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sq_q <= adsq_pkg::SQ_IDLE;
            slot_q <= 2'h0;
            sync_q <= 2'h0;
            hold_q <= 8'h00;
            ccf_q <= 1'b0; // RULE_09
        end else begin
            sq_q <= sq_d;
            slot_q <= slot_d;
            sync_q <= sync_d;
            hold_q <= hold_d;
            ccf_q <= ccf_d;
        end
    end

    // Results have no reset, only conversions write them
    always_ff @(posedge CLK_I) begin
        for (int i = 0; i < 4; i++) begin
            res_q[i] <= res_d[i]; // RULE_07
        end
    end

    adsq_sar u_sar (
        .clk_i(CLK_I),
        .rst_n_i(rst_n_q),
        .start_i(sar_start),
        .step_i(sar_step),
        .comp_i(clock_source_select ? comp_q : COMP_I),
        .sample_o(sar_sample),
        .trial_o(sar_trial),
        .done_o(sar_done),
        .result_o(sar_res)
    );

    // Front-end drive, all outputs registered
    logic [7:0] pin_d;
    logic [7:0] pin_q;
    logic hi_d;
    logic hi_q;
    logic lo_d;
    logic lo_q;
    logic half_d;
    logic half_q;
    logic samp_q;
    logic [7:0] dac_q;
    logic pump_q;
    logic rcen_q;
    logic active;

    assign active = (sq_q != adsq_pkg::SQ_IDLE);

    // Reserved codes route nothing, pin decode per channel
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign pin_d[g] = active && (cur_ch == 4'(g)); // RULE_01
        end
    endgenerate

    always_comb begin
        hi_d = active && (cur_ch == `ADSQ_CH_REF_HI); // RULE_16
        lo_d = active && (cur_ch == `ADSQ_CH_REF_LO); // RULE_16
        // No divider exists; capacitors are forced while sampling
        half_d = sar_sample && (cur_ch == `ADSQ_CH_HALF); // RULE_17
    end

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_q <= 8'h00;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            half_q <= 1'b0;
            samp_q <= 1'b0;
            dac_q <= 8'h00;
            pump_q <= 1'b0;
            rcen_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            half_q <= half_d;
            samp_q <= sar_sample; // RULE_20
            dac_q <= sar_trial;
            pump_q <= opt_q[`ADSQ_OPT_PU]; // RULE_22
            rcen_q <= opt_q[`ADSQ_OPT_PU] && clock_source_select;
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;
    assign PIN_SEL_O = pin_q;
    assign REF_HI_O = hi_q;
    assign REF_LO_O = lo_q;
    assign HALF_REF_O = half_q;
    assign SAMPLE_O = samp_q;
    assign DAC_CODE_O = dac_q;
    assign PUMP_EN_O = pump_q;
    assign RC_OSC_EN_O = rcen_q;

endmodule

// ---- tb/adsq_analog_model.sv ----
// Analog front end model: pins, references, hold cap and RC oscillator
`timescale 1ns/100ps
module adsq_analog_model (
    // Clock
    input wire logic clk_i,
    // Level shift applied to all pins
    input wire logic [7:0] bias_i,
    // Routing from the block
    input wire logic [7:0] pin_sel_i,
    input wire logic ref_hi_i,
    input wire logic ref_lo_i,
    input wire logic half_ref_i,
    input wire logic sample_i,
    input wire logic [7:0] dac_i,
    input wire logic rc_en_i,
    // Back to the block
    output logic comp_o,
    output logic rc_osc_o
);
    logic [7:0] live;
    logic [7:0] held_q;

    // Nothing routed: floating node, changes every cycle
    always_comb begin
        live = 8'hA5 ^ {8{clk_i}};
        for (int k = 0; k < 8; k++) begin
            if (pin_sel_i[k]) begin
                live = 8'(k * 16 + 5) + bias_i;
            end
        end
        if (ref_hi_i) begin
            live = 8'hFF;
        end
        if (ref_lo_i) begin
            live = 8'h00;
        end
        if (half_ref_i) begin
            live = 8'h80;
        end
    end

    // Charge taken only while the switch is closed
    always @(posedge clk_i) begin
        if (sample_i) begin
            held_q <= live;
        end
    end

    assign comp_o = held_q >= dac_i;

    // Oscillator stands still unless enabled, about 2 MHz
    initial begin
        rc_osc_o = 1'b0;
        forever begin
            #250 rc_osc_o = rc_en_i ? ~rc_osc_o : 1'b0;
        end
    end
endmodule

// ---- tb/adsq_top_props.sv ----
// Port-level checks of the converter sequencer
`timescale 1ns/100ps
module adsq_top_props (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Bus
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:2] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    // Analog side
    input wire logic [7:0] PIN_SEL_O,
    input wire logic REF_HI_O,
    input wire logic REF_LO_O,
    input wire logic HALF_REF_O,
    input wire logic SAMPLE_O,
    input wire logic PUMP_EN_O,
    input wire logic RC_OSC_EN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    property p_route;
        $onehot0({PIN_SEL_O, REF_HI_O, REF_LO_O, HALF_REF_O});
    endproperty
    a_route: assert property (p_route)
        else $error("more than one source routed");
    property p_half;
        HALF_REF_O |-> SAMPLE_O;
    endproperty
    a_half: assert property (p_half)
        else $error("half reference outside sample");
    // Length of the current closed-switch run, saturating
    logic [4:0] run_q;
    always_ff @(posedge CLK_I) begin
        if (!SAMPLE_O) begin
            run_q <= 5'h00;
        end else if (run_q != 5'h1F) begin
            run_q <= run_q + 5'h01;
        end
    end
    // RC steps stretch the sample, so only bus clocking is timed
    property p_sample;
        $fell(SAMPLE_O) && !RC_OSC_EN_O |-> run_q == 5'h0C;
    endproperty
    a_sample: assert property (p_sample)
        else $error("sample length not twelve");
    property p_gap;
        $fell(SAMPLE_O) && !RC_OSC_EN_O
            |-> (!SAMPLE_O)[*8] or ##[0:8] (ACK_O && WE_I);
    endproperty
    a_gap: assert property (p_gap)
        else $error("sample reopened too early");
    property p_bit6;
        ACK_O && !WE_I && ADR_I == 3'h0
            |-> DAT_O[6] == 1'b0 && DAT_O[31:8] == 24'h0;
    endproperty
    a_bit6: assert property (p_bit6)
        else $error("control bit 6 not zero");
    property p_start;
        ACK_O && WE_I && ADR_I == 3'h0 && SEL_I[0] |-> ##[1:3] SAMPLE_O;
    endproperty
    a_start: assert property (p_start)
        else $error("control write did not start sampling");
    property p_pump;
        $rose(RST_B_I) |-> (!PUMP_EN_O)[*2];
    endproperty
    a_pump: assert property (p_pump)
        else $error("pump on after reset");
    property p_rc;
        RC_OSC_EN_O |-> PUMP_EN_O;
    endproperty
    a_rc: assert property (p_rc)
        else $error("oscillator on without power");
    property p_ack;
        ACK_O |=> !ACK_O;
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack longer than one cycle");
endmodule

bind adsq_top adsq_top_props u_props (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .PIN_SEL_O(PIN_SEL_O),
    .REF_HI_O(REF_HI_O), .REF_LO_O(REF_LO_O), .HALF_REF_O(HALF_REF_O),
    .SAMPLE_O(SAMPLE_O), .PUMP_EN_O(PUMP_EN_O), .RC_OSC_EN_O(RC_OSC_EN_O));

// ---- tb/adsq_top_tb_top.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module adsq_top_tb_top;
    logic CLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    logic CYC_I = 1'b0;
    logic STB_I = 1'b0;
    logic WE_I = 1'b0;
    logic [4:2] ADR_I = 3'h0;
    logic [3:0] SEL_I = 4'h0;
    logic [31:0] DAT_I = 32'h0;
    logic [31:0] DAT_O;
    logic ACK_O, COMP_I, RC_OSC_I, REF_HI_O, REF_LO_O, HALF_REF_O;
    logic SAMPLE_O, PUMP_EN_O, RC_OSC_EN_O;
    logic [7:0] PIN_SEL_O, DAC_CODE_O, rd;
    logic [7:0] bias = 8'h00;
    int n_mismatch = 0;
    int n_checks = 0;

    adsq_top u_dut (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(CYC_I),
        .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
        .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .COMP_I(COMP_I),
        .RC_OSC_I(RC_OSC_I), .PIN_SEL_O(PIN_SEL_O), .REF_HI_O(REF_HI_O),
        .REF_LO_O(REF_LO_O), .HALF_REF_O(HALF_REF_O), .SAMPLE_O(SAMPLE_O),
        .DAC_CODE_O(DAC_CODE_O), .PUMP_EN_O(PUMP_EN_O),
        .RC_OSC_EN_O(RC_OSC_EN_O));
    adsq_analog_model u_model (.clk_i(CLK_I), .bias_i(bias),
        .pin_sel_i(PIN_SEL_O), .ref_hi_i(REF_HI_O), .ref_lo_i(REF_LO_O),
        .half_ref_i(HALF_REF_O), .sample_i(SAMPLE_O), .dac_i(DAC_CODE_O),
        .rc_en_i(RC_OSC_EN_O), .comp_o(COMP_I), .rc_osc_o(RC_OSC_I));

    initial begin
        forever begin
            #10 CLK_I = ~CLK_I;
        end
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic cycle; the leading edge keeps a gap between requests
    task automatic wb(input logic [2:0] a, input logic w, input logic [7:0] d);
        @(posedge CLK_I);
        // Ack of the previous request must already be gone
        chk("ack idle", 8'h00, {7'h0, ACK_O});
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        SEL_I <= 4'hF;
        DAT_I <= {24'h0, d};
        do begin
            @(posedge CLK_I);
        end while (ACK_O !== 1'b1);
        rd = DAT_O[7:0];
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I <= 1'b0;
    endtask

    function automatic logic [7:0] pin_val(input int k);
        return 8'(k * 16 + 5) + bias;
    endfunction

    task automatic wait_flag(input int lim);
        int n;
        n = 0;
        do begin
            wb(3'h0, 1'b0, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < lim);
        chk("flag", 8'h01, {7'h0, rd[7]});
    endtask

    task automatic chk_res(input logic [31:0] e);
        for (int i = 0; i < 4; i++) begin
            wb(3'(i + 1), 1'b0, 8'h00);
            chk("result", e[8*i+:8], rd);
        end
    endtask

    task automatic t_single();
        wb(3'h0, 1'b1, 8'h43);
        wait_flag(60);
        wb(3'h0, 1'b0, 8'h00);
        chk("ctl", 8'h83, rd);
        chk_res({4{pin_val(3)}});
        wb(3'h1, 1'b1, 8'h55);
        wb(3'h1, 1'b0, 8'h00);
        chk("ro", pin_val(3), rd);
    endtask

    // Read acked at W+33 sees the old value, later the new one
    task automatic t_timing();
        wb(3'h0, 1'b1, 8'h01);
        repeat (30) @(posedge CLK_I);
        wb(3'h1, 1'b0, 8'h00);
        chk("early", pin_val(3), rd);
        wb(3'h1, 1'b0, 8'h00);
        chk("w34", pin_val(1), rd);
        wait_flag(60);
    endtask

    task automatic t_scan();
        wb(3'h0, 1'b1, 8'h37);
        wait_flag(60);
        chk_res({pin_val(7), pin_val(6), pin_val(5), pin_val(4)});
        bias <= 8'h02;
        repeat (300) @(posedge CLK_I);
        wb(3'h0, 1'b0, 8'h00);
        chk("scan", 8'hB7, rd);
        chk_res({pin_val(7), pin_val(6), pin_val(5), pin_val(4)});
    endtask

    // Abort between samples, then each reference code
    task automatic t_codes();
        logic [7:0] ex [3] = '{8'hFF, 8'h00, 8'h80};
        int n;
        n = 0;
        while (SAMPLE_O !== 1'b1 && n < 100) begin
            @(posedge CLK_I);
            n++;
        end
        while (SAMPLE_O !== 1'b0 && n < 200) begin
            @(posedge CLK_I);
            n++;
        end
        for (int c = 0; c < 3; c++) begin
            wb(3'h0, 1'b1, 8'(12 + c));
            wb(3'h0, 1'b0, 8'h00);
            chk("abort", 8'(12 + c), rd);
            wait_flag(60);
            chk_res({4{ex[c]}});
        end
    endtask

    task automatic t_rc();
        wb(3'h5, 1'b1, 8'h03);
        wb(3'h0, 1'b1, 8'h02);
        chk("rc en", 8'h03, {6'h0, PUMP_EN_O, RC_OSC_EN_O});
        wait_flag(1500);
        chk_res({4{pin_val(2)}});
        wb(3'h5, 1'b1, 8'h02);
    endtask

    task automatic t_reset();
        RST_B_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        wb(3'h0, 1'b0, 8'h00);
        chk("rst ctl", 8'h02, rd);
        wb(3'h5, 1'b0, 8'h00);
        chk("rst opt", 8'h00, rd);
        wb(3'h6, 1'b0, 8'h00);
        chk("unmapped", 8'h00, rd);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        wb(3'h0, 1'b0, 8'h00);
        chk("flag rst", 8'h00, {7'h0, rd[7]});
        wb(3'h5, 1'b1, 8'h02);
        t_single();
        t_timing();
        t_scan();
        t_codes();
        t_rc();
        t_reset();
        test_done();
    end

    initial begin
        repeat (60000) @(posedge CLK_I);
        n_mismatch++;
        test_done();
    end
endmodule
